// File: core/ddr2_burst_command_timing.sv
`timescale 1ns/1ps
module ddr2_burst_command_timing (
  input  wire logic                        clk,          // 20 MHz clock.
  input  wire logic                        rst_n,        // Asynchronous reset, active low.
  input  wire logic                        clk_en,       // Freezes all state while low.
  input  wire burst_timing_pkg::command_t  cmd_in,       // Command, bank and address.
  input  wire logic [15:0]                 wdata,        // Write data word.
  input  wire logic                        on_die_termination, // Termination pin.
  output logic [15:0]                      dq_o,         // Data driven out.
  output logic                             dq_oe,        // High while data pins driven.
  output logic                             rd_valid,     // Read data word on dq_o.
  output logic                             wr_take,      // Write word sampled this cycle.
  output logic [63:0]                      adjust_pattern_words, // Four adjust words.
  output logic                             adjust_done,  // Pulse: pattern complete.
  output logic                             access_error, // Pulse: access to idle bank.
  output logic [3:0]                       bank_open,    // Activated bank map.
  output burst_timing_pkg::mode_t          mode_q,       // Programmed modes.
  output logic [3:0]                       read_latency, // Effective read latency.
  output logic                             termination_on // Termination active.
);

  // ------------------------------------------------------------
  // Command register and decode
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CAL_OFF    = 4'h1,
    CAL_DRIVE  = 4'h2,
    CAL_ADJUST = 4'h4,
    CAL_EXIT   = 4'h8
  } cal_state_t;

  burst_timing_pkg::command_t cmd_q;
  cal_state_t                 cal_q;
  logic [3:0]                 cal_cnt_q;
  logic                       cal_drive_q;
  logic [3:0]                 rd_sh_q;
  logic [15:0]                rd_cnt_q;
  logic [3:0]                 wr_cnt_q;
  logic [1:0]                 adj_idx_q;
  logic [3:0]                 wlat_q;
  logic [15:0]                rd_pipe_q;
  logic [15:0]                wr_pipe_q;
  logic [3:0]                 burst_words;

  // Commands are captured on the rising edge before anything acts on them.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= '{cmd: burst_timing_pkg::CMD_NOP, bank: 2'h0, addr: 14'h0};
    end else if (clk_en) begin
      cmd_q <= cmd_in;
    end
  end

  wire is_rd  = cmd_q.cmd == burst_timing_pkg::CMD_READ;
  wire is_wr  = cmd_q.cmd == burst_timing_pkg::CMD_WRITE;
  wire is_mrs = cmd_q.cmd == burst_timing_pkg::CMD_MRS;
  wire hit    = bank_open[cmd_q.bank];
  wire [2:0] cal_code = cmd_q.addr[burst_timing_pkg::CAL_MODE_LSB +: 3];

  assign burst_words = mode_q.burst8 ? 4'h8 : 4'h4;

  // ------------------------------------------------------------
  // Bank tracking
  // ------------------------------------------------------------
  // Accesses to a bank that is not activated are dropped and flagged.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_open    <= 4'h0;
      access_error <= 1'b0;
    end else if (clk_en) begin
      access_error <= (is_rd || is_wr) && !hit;
      if (cmd_q.cmd == burst_timing_pkg::CMD_ACT) begin
        bank_open[cmd_q.bank] <= 1'b1;
      end else if (cmd_q.cmd == burst_timing_pkg::CMD_PRE) begin
        if (cmd_q.addr[burst_timing_pkg::AP_BIT]) begin
          bank_open <= 4'h0;
        end else begin
          bank_open[cmd_q.bank] <= 1'b0;
        end
      end else if ((is_rd || is_wr) && hit && cmd_q.addr[burst_timing_pkg::AP_BIT]) begin
        bank_open[cmd_q.bank] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Mode registers
  // ------------------------------------------------------------
  // Mode and first extended register writes; latency fields are loaded from the address unchecked.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= '{additive_latency: burst_timing_pkg::ADD_LAT_RESET,
                  column_access_delay: burst_timing_pkg::CAS_DLY_RESET,
                  burst8: 1'b0, rtt_nominal: burst_timing_pkg::RTT_RESET};
    end else if (clk_en && is_mrs) begin
      if (cmd_q.bank == burst_timing_pkg::BA_MODE) begin
        mode_q.burst8 <= cmd_q.addr[burst_timing_pkg::BURST8_BIT];
        mode_q.column_access_delay <= cmd_q.addr[burst_timing_pkg::CAS_DLY_LSB +: 3];
      end else if (cmd_q.bank == burst_timing_pkg::BA_EXT1) begin
        mode_q.additive_latency <= cmd_q.addr[burst_timing_pkg::ADD_LAT_LSB +: 3];
        mode_q.rtt_nominal <= {cmd_q.addr[burst_timing_pkg::RTT_HI_BIT],
                               cmd_q.addr[burst_timing_pkg::RTT_LO_BIT]};
      end
    end
  end

  // Latency sums: read is additive plus column, write one clock less.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_latency <= 4'h3;
      wlat_q       <= 4'h2;
    end else if (clk_en) begin
      read_latency <= 4'(mode_q.additive_latency) + 4'(mode_q.column_access_delay);
      wlat_q <= 4'(mode_q.additive_latency) + 4'(mode_q.column_access_delay) - 4'h1;
    end
  end

  // Termination follows the pin only when a resistance is programmed.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      termination_on <= 1'b0;
    end else if (clk_en) begin
      termination_on <= on_die_termination && (mode_q.rtt_nominal != 2'h0);
    end
  end

  // ------------------------------------------------------------
  // Driver calibration state machine
  // ------------------------------------------------------------
  // Drivers change state only after the calibration delay has run out.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_q       <= CAL_OFF;
      cal_cnt_q   <= 4'h0;
      cal_drive_q <= 1'b0;
    end else if (clk_en) begin
      if (cal_cnt_q != 4'h0) begin
        cal_cnt_q <= cal_cnt_q - 4'h1;
      end
      case (cal_q)
        CAL_OFF, CAL_EXIT: begin
          if (cal_q == CAL_EXIT && cal_cnt_q == 4'h1) begin
            cal_drive_q <= 1'b0;
            cal_q <= CAL_OFF;
          end
          if (is_mrs && cmd_q.bank == burst_timing_pkg::BA_EXT1) begin
            if (cal_code == burst_timing_pkg::CAL_CMD_HIGH ||
                cal_code == burst_timing_pkg::CAL_CMD_LOW) begin
              cal_q     <= CAL_DRIVE;
              cal_cnt_q <= burst_timing_pkg::CAL_CYCLES;
            end else if (cal_code == burst_timing_pkg::CAL_CMD_ADJ) begin
              cal_q <= CAL_ADJUST;
            end
          end
        end
        CAL_DRIVE: begin
          if (cal_cnt_q == 4'h1) begin
            cal_drive_q <= 1'b1;
          end
          if (is_mrs && cal_code == burst_timing_pkg::CAL_CMD_EXIT) begin
            cal_q     <= CAL_EXIT;
            cal_cnt_q <= burst_timing_pkg::CAL_CYCLES;
          end
        end
        CAL_ADJUST: begin
          if (is_mrs && cal_code == burst_timing_pkg::CAL_CMD_EXIT) begin
            cal_q <= CAL_OFF;
          end
        end
        default: cal_q <= CAL_OFF;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Latency pipeline for reads and writes
  // ------------------------------------------------------------
  // One delay line per direction, so a command two clocks behind another cannot
  // cancel the earlier one's data; bit 0 marks the clock at which a burst starts.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pipe_q <= 16'h0000;
      wr_pipe_q <= 16'h0000;
    end else if (clk_en) begin
      rd_pipe_q <= (rd_pipe_q >> 1) |
                   ((is_rd && hit) ? (16'h0001 << read_latency) : 16'h0000);
      wr_pipe_q <= (wr_pipe_q >> 1) |
                   ((is_wr && hit) ? (16'h0001 << wlat_q) : 16'h0000);
    end
  end

  // Burst beat counters, two words per clock collapsed to one word per cycle.
  // A burst of four appends to the running one so that seamless bursts stay
  // gapless; a burst of eight restarts the count, which is the interrupt case.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_sh_q  <= 4'h0;
      wr_cnt_q <= 4'h0;
    end else if (clk_en) begin
      if (rd_pipe_q[0]) begin
        rd_sh_q <= burst_words + ((mode_q.burst8 || rd_sh_q == 4'h0) ?
                                  4'h0 : rd_sh_q - 4'h1);
      end else if (rd_sh_q != 4'h0) begin
        rd_sh_q <= rd_sh_q - 4'h1;
      end
      if (wr_pipe_q[0]) begin
        wr_cnt_q <= burst_words + ((mode_q.burst8 || wr_cnt_q == 4'h0) ?
                                   4'h0 : wr_cnt_q - 4'h1);
      end else if (wr_cnt_q != 4'h0) begin
        wr_cnt_q <= wr_cnt_q - 4'h1;
      end
    end
  end

  // Read data and driver enable; calibration drive overrides the data path.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_o     <= 16'h0000;
      dq_oe    <= 1'b0;
      rd_valid <= 1'b0;
      rd_cnt_q <= 16'h0000;
    end else if (clk_en) begin
      rd_valid <= rd_sh_q != 4'h0;
      if (rd_sh_q != 4'h0) begin
        rd_cnt_q <= rd_cnt_q + 16'h0001;
      end
      dq_o  <= cal_drive_q ? 16'hFFFF : rd_cnt_q;
      dq_oe <= cal_drive_q || (rd_sh_q != 4'h0);
    end
  end

  // Write beats, and the four adjust words in fixed arrival order.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_take              <= 1'b0;
      adj_idx_q            <= 2'h0;
      adjust_pattern_words <= 64'h0;
      adjust_done          <= 1'b0;
    end else if (clk_en) begin
      wr_take     <= wr_cnt_q != 4'h0;
      adjust_done <= 1'b0;
      if (wr_cnt_q != 4'h0 && cal_q == CAL_ADJUST && adj_idx_q == 2'h0 &&
          wr_cnt_q != burst_words) begin
        adj_idx_q <= 2'h0;
      end
      if (wr_cnt_q != 4'h0 && cal_q == CAL_ADJUST) begin
        adjust_pattern_words[adj_idx_q*16 +: 16] <= wdata;
        adj_idx_q <= adj_idx_q + 2'h1;
        adjust_done <= adj_idx_q == 2'h3;
      end else if (wr_cnt_q == 4'h0) begin
        adj_idx_q <= 2'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_read_latency_sum: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> read_latency ==
      4'($past(mode_q.additive_latency)) + 4'($past(mode_q.column_access_delay)))
    else $error("read latency differs from sum");
  a_write_one_less: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> wlat_q == read_latency - 4'h1 || !$stable(mode_q) || !$past(clk_en))
    else $error("write latency not one below read latency");
  a_idle_bank_error: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && (is_rd || is_wr) && !hit |=> access_error &&
      rd_pipe_q == ($past(rd_pipe_q) >> 1) && wr_pipe_q == ($past(wr_pipe_q) >> 1))
    else $error("access to idle bank not refused");
  a_rtt_update: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && is_mrs && cmd_q.bank == burst_timing_pkg::BA_EXT1 |=>
      mode_q.rtt_nominal == {$past(cmd_q.addr[6]), $past(cmd_q.addr[2])})
    else $error("termination bits not updated");
  a_drive_off_exit: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && cal_q == CAL_OFF && !cal_drive_q |=> !cal_drive_q || !$past(clk_en))
    else $error("drivers turned on outside drive mode");
  a_adjust_order: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && wr_cnt_q != 4'h0 && cal_q == CAL_ADJUST |=>
      adjust_pattern_words[$past(adj_idx_q)*16 +: 16] == $past(wdata))
    else $error("adjust word stored out of order");
  a_read_burst_len: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && rd_pipe_q[0] && (mode_q.burst8 || rd_sh_q == 4'h0) |=> rd_sh_q == burst_words)
    else $error("read burst not programmed length");
  a_write_burst_len: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && wr_pipe_q[0] && (mode_q.burst8 || wr_cnt_q == 4'h0) |=> wr_cnt_q == burst_words)
    else $error("write burst not programmed length");
  c_read_burst: cover property (@(posedge clk) disable iff (!rst_n) rd_valid [*4]);
  c_write_burst: cover property (@(posedge clk) disable iff (!rst_n) wr_take [*4]);
  c_adjust: cover property (@(posedge clk) disable iff (!rst_n) adjust_done);

endmodule

// File: core/burst_timing_pkg.sv
package burst_timing_pkg;

  // ----------------------------------------
  // Command encodings (cs, ras, cas, we)
  // ----------------------------------------
  localparam logic [3:0] CMD_NOP    = 4'h7;
  localparam logic [3:0] CMD_ACT    = 4'h3;
  localparam logic [3:0] CMD_READ   = 4'h5;
  localparam logic [3:0] CMD_WRITE  = 4'h4;
  localparam logic [3:0] CMD_PRE    = 4'h2;
  localparam logic [3:0] CMD_REF    = 4'h1;
  localparam logic [3:0] CMD_MRS    = 4'h0;

  // ----------------------------------------
  // Mode register fields and reset values
  // ----------------------------------------
  localparam int          BURST8_BIT    = 3;
  localparam int          AP_BIT        = 10;
  localparam int          CAS_DLY_LSB   = 4;
  localparam int          ADD_LAT_LSB   = 3;
  localparam int          CAL_MODE_LSB  = 7;
  localparam int          RTT_HI_BIT    = 6;
  localparam int          RTT_LO_BIT    = 2;
  localparam logic [1:0]  BA_MODE       = 2'h0;
  localparam logic [1:0]  BA_EXT1       = 2'h1;
  localparam logic [2:0]  CAL_CMD_EXIT  = 3'h0;
  localparam logic [2:0]  CAL_CMD_HIGH  = 3'h1;
  localparam logic [2:0]  CAL_CMD_LOW   = 3'h2;
  localparam logic [2:0]  CAL_CMD_ADJ   = 3'h4;
  localparam logic [2:0]  CAS_DLY_RESET = 3'h3;
  localparam logic [2:0]  ADD_LAT_RESET = 3'h0;
  localparam logic [1:0]  RTT_RESET     = 2'h0;

  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam int          CLK_MHZ       = 20;
  localparam int          CAL_DELAY_NS  = 12;
  localparam int          CAL_CYC_INT   = (CAL_DELAY_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
                                          (CAL_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  CAL_CYCLES    = 4'(CAL_CYC_INT);

  typedef struct packed {
    logic [3:0]  cmd;
    logic [1:0]  bank;
    logic [13:0] addr;
  } command_t;

  typedef struct packed {
    logic [2:0] additive_latency;
    logic [2:0] column_access_delay;
    logic       burst8;
    logic [1:0] rtt_nominal;
  } mode_t;

endpackage

// File: test/ctl_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Controller model on the command side
// ----------------------------------------
module ctl_model #(
  parameter int OFF_DLY = 3,  // Termination off delay in cycles.
  parameter int MOD_WIN = 12  // Mode update window in cycles.
) (
  input  wire logic                  clk,      // Device clock.
  input  wire logic                  wr_take,  // Write beat strobe.
  output burst_timing_pkg::command_t cmd,      // Command bus.
  output logic [15:0]                wdata,    // Write word.
  output logic                       term_pin  // Termination pin.
);
  logic [15:0] pat [4];
  int          idx;

  // Pin stays low through initialization so termination is off.
  initial begin
    cmd = '{burst_timing_pkg::CMD_NOP, 2'h0, 14'h0000};
    term_pin = 1'b0;
    wdata = 16'h0000;
    idx = 4;
    pat = '{16'h1A2B, 16'h3C4D, 16'h5E6F, 16'h7081};
  end

  // Next word per taken beat; idle data toggles so stale words never pass.
  always @(negedge clk) begin
    if (wr_take === 1'b1) idx = idx + 1;
    wdata <= (idx < 4) ? pat[idx] : ~wdata;
  end

  // One command for one cycle, then a no-op; back-to-back calls are two apart.
  task automatic send(input logic [3:0] c, input logic [1:0] ba, input logic [13:0] a);
    @(negedge clk);
    cmd <= '{c, ba, a};
    @(negedge clk);
    cmd.cmd <= burst_timing_pkg::CMD_NOP;
  endtask

  // Termination dropped before and held low across the mode update.
  task automatic ext_mode_set(input logic [1:0] ba, input logic [13:0] a);
    @(negedge clk);
    term_pin <= 1'b0;
    repeat (OFF_DLY) @(negedge clk);
    send(burst_timing_pkg::CMD_MRS, ba, a);
    repeat (MOD_WIN) @(negedge clk);
    term_pin <= 1'b1;
  endtask

  // Self refresh is never entered, so no bank or termination shutdown is needed.
  task automatic arm();
    @(posedge clk);
    idx = 0;
    wdata <= pat[0];
  endtask
endmodule

// File: test/ddr2_burst_command_timing_test.sv
`timescale 1ns/1ps
module ddr2_burst_command_timing_test;
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, on_die_termination;
  burst_timing_pkg::command_t cmd_in;
  logic [15:0] wdata, dq_o;
  logic dq_oe, rd_valid, wr_take, adjust_done, access_error, termination_on;
  logic [63:0] adjust_pattern_words;
  logic [3:0] bank_open, read_latency;
  burst_timing_pkg::mode_t mode_q;
  int fails = 0, n_tests = 0, cyc = 0, t0, rl0, rlat, wlat;
  int n_rd, n_wr, n_err, n_adj, rd_f, rd_l, wr_f, wr_l;

  always #25 clk = ~clk;

  ddr2_burst_command_timing dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .cmd_in(cmd_in), .wdata(wdata), .on_die_termination(on_die_termination),
    .dq_o(dq_o), .dq_oe(dq_oe), .rd_valid(rd_valid), .wr_take(wr_take),
    .adjust_pattern_words(adjust_pattern_words), .adjust_done(adjust_done),
    .access_error(access_error), .bank_open(bank_open), .mode_q(mode_q),
    .read_latency(read_latency), .termination_on(termination_on));

  ctl_model ctl_u (.clk(clk), .wr_take(wr_take), .cmd(cmd_in), .wdata(wdata),
    .term_pin(on_die_termination));

  // ----------------------------------------
  // Beat monitor, sampled mid-cycle
  // ----------------------------------------
  always @(negedge clk) begin
    cyc = cyc + 1;
    if (rd_valid === 1'b1) begin
      if (n_rd == 0) rd_f = cyc;
      rd_l = cyc;
      n_rd++;
    end
    if (wr_take === 1'b1) begin
      if (n_wr == 0) wr_f = cyc;
      wr_l = cyc;
      n_wr++;
    end
    if (access_error === 1'b1) n_err++;
    if (adjust_done === 1'b1) n_adj++;
  end

  // Clears counts at the edge after the one taking the last command, then lets beats run.
  task automatic window(input int n);
    @(posedge clk);
    {n_rd, n_wr, n_err, n_adj} = '0;
    t0 = cyc;
    repeat (n) @(posedge clk);
    rlat = rd_f - t0;
    wlat = wr_f - t0;
  endtask

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Bursts of a given command, counted and checked for no gaps.
  task automatic burst(input logic [3:0] c, input int k, input int exp, input logic ap);
    for (int i = 0; i < k; i++) ctl_u.send(c, 2'h0, {3'h0, ap & (i == k - 1), 10'h000});
    window(30);
    if (c == burst_timing_pkg::CMD_READ) begin
      check("rd_beats", n_rd, exp);
      check("rd_span", rd_l - rd_f + 1, exp);
    end else begin
      check("wr_beats", n_wr, exp);
      check("wr_span", wr_l - wr_f + 1, exp);
    end
  endtask

  // Bound on the whole run; the sequence needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    check("rlat_rst", read_latency, 4'h3);
    check("banks_rst", bank_open, 4'h0);
    check("term_init", termination_on, 1'b0);
    ctl_u.ext_mode_set(burst_timing_pkg::BA_MODE, 14'h0030);
    ctl_u.ext_mode_set(burst_timing_pkg::BA_EXT1, 14'h0044);
    // The pin was raised at this edge; one clock lets the flag register it.
    @(negedge clk);
    check("rtt", mode_q.rtt_nominal, 2'h3);
    check("term_on", termination_on, 1'b1);
    ctl_u.send(burst_timing_pkg::CMD_ACT, 2'h0, 14'h0000);
    ctl_u.send(burst_timing_pkg::CMD_READ, 2'h2, 14'h0000);
    window(12);
    check("closed_err", n_err, 1);
    check("closed_rd", n_rd, 0);
    check("open_map", bank_open, 4'h1);
    // Windows of 30 cycles keep every turnaround far above its minimum.
    burst(burst_timing_pkg::CMD_READ, 1, 4, 1'b0);
    rl0 = rlat;
    burst(burst_timing_pkg::CMD_WRITE, 1, 4, 1'b0);
    check("wlat_rlat", rl0 - wlat, 1);
    burst(burst_timing_pkg::CMD_READ, 2, 8, 1'b0);
    burst(burst_timing_pkg::CMD_WRITE, 2, 8, 1'b0);
    ctl_u.ext_mode_set(burst_timing_pkg::BA_EXT1, 14'h0054);
    check("rlat_add2", read_latency, 4'h5);
    burst(burst_timing_pkg::CMD_READ, 1, 4, 1'b0);
    check("addlat_shift", rlat - rl0, 2);
    ctl_u.ext_mode_set(burst_timing_pkg::BA_EXT1, 14'h0044);
    ctl_u.ext_mode_set(burst_timing_pkg::BA_MODE, 14'h0038);
    burst(burst_timing_pkg::CMD_READ, 1, 8, 1'b0);
    burst(burst_timing_pkg::CMD_READ, 2, 10, 1'b1);
    ctl_u.send(burst_timing_pkg::CMD_ACT, 2'h0, 14'h0000);
    burst(burst_timing_pkg::CMD_WRITE, 2, 10, 1'b1);
    ctl_u.send(burst_timing_pkg::CMD_ACT, 2'h0, 14'h0000);
    ctl_u.ext_mode_set(burst_timing_pkg::BA_EXT1, 14'h00C4);
    check("drv_oe", dq_oe, 1'b1);
    check("drv_dq", dq_o, 16'hFFFF);
    ctl_u.ext_mode_set(burst_timing_pkg::BA_EXT1, 14'h0044);
    check("drv_off", dq_oe, 1'b0);
    // The adjust pattern is four words, so the burst of four is programmed first.
    ctl_u.ext_mode_set(burst_timing_pkg::BA_MODE, 14'h0030);
    ctl_u.ext_mode_set(burst_timing_pkg::BA_EXT1, 14'h0244);
    ctl_u.arm();
    ctl_u.send(burst_timing_pkg::CMD_WRITE, 2'h0, 14'h0000);
    window(30);
    check("adj_done", n_adj, 1);
    check("adj_words", adjust_pattern_words, 64'h70815E6F3C4D1A2B);
    ctl_u.ext_mode_set(burst_timing_pkg::BA_EXT1, 14'h0044);
    print_verdict();
  end
endmodule
